// file: logic/amb_divider.sv
// Sequential unsigned restoring divider for one monitor channel
`timescale 1ns/1ps
module amb_divider #(
  parameter int NUM_W = amb_pkg::NUM_W,
  parameter int DEN_W = amb_pkg::DEN_W
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] numer,
  input  wire logic [DEN_W-1:0] denom,
  output logic                  done,
  output logic [NUM_W-1:0]      quot
);
  import amb_pkg::*;
  localparam int CNT_W   = $clog2(NUM_W + 1);
  // Done is registered, so it rises on the same edge as the last quotient bit
  localparam int DIV_LAT = NUM_W + 1;

  amb_div_t         state_r, state_nxt;
  logic [DEN_W-1:0] rem_r, rem_nxt, den_r, den_nxt;
  logic [NUM_W-1:0] quo_r, quo_nxt, orgNum_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             done_r, done_nxt;
  logic [DEN_W:0]   trial;

  ////////////////////////////////////////////////////////////////////////////
  // One quotient bit per cycle; zero divisor yields all ones, read as saturation
  always_comb begin
    state_nxt = state_r;
    rem_nxt   = rem_r;
    den_nxt   = den_r;
    quo_nxt   = quo_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    trial     = {rem_r, quo_r[NUM_W-1]};
    unique case (state_r)
      DIV_IDLE: begin
        if (start) begin
          rem_nxt   = '0;
          den_nxt   = denom;
          quo_nxt   = numer;
          cnt_nxt   = CNT_W'(NUM_W);
          state_nxt = DIV_RUN;
        end
      end
      DIV_RUN: begin
        if (trial >= {1'b0, den_r}) begin
          rem_nxt = DEN_W'(trial - {1'b0, den_r});
          quo_nxt = {quo_r[NUM_W-2:0], 1'b1};
        end else begin
          rem_nxt = trial[DEN_W-1:0];
          quo_nxt = {quo_r[NUM_W-2:0], 1'b0};
        end
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == CNT_W'(1)) begin
          state_nxt = DIV_IDLE;
          done_nxt  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= DIV_IDLE;
      rem_r   <= '0;
      den_r   <= '0;
      quo_r   <= '0;
      cnt_r   <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rem_r   <= rem_nxt;
      den_r   <= den_nxt;
      quo_r   <= quo_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  // Copy of the dividend kept only for checking
  always_ff @(posedge clk) begin
    if (state_r == DIV_IDLE && start) begin
      orgNum_r <= numer;
    end
  end

  assign done = done_r;
  assign quot = quo_r;

  a_div_exact: assert property (@(posedge clk) disable iff (!rstN)
    (done_r && den_r != '0) |-> ({8'h00, quo_r} * {{NUM_W+8-DEN_W{1'b0}}, den_r}
      <= {8'h00, orgNum_r}) && ({8'h00, orgNum_r} - {8'h00, quo_r} *
      {{NUM_W+8-DEN_W{1'b0}}, den_r} < {{NUM_W+8-DEN_W{1'b0}}, den_r}))
    else $error("divider quotient wrong");
  a_div_latency: assert property (@(posedge clk) disable iff (!rstN)
    (state_r == DIV_IDLE && start) |-> ##DIV_LAT done_r)
    else $error("divider latency wrong");
endmodule

// file: logic/amb_pkg.sv
// Constants and types for the analog monitor and brake interlock block
package amb_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_SRC_SEL  = 8'h00;
  localparam logic [7:0] ADDR_OFF_CH1  = 8'h04;
  localparam logic [7:0] ADDR_OFF_CH2  = 8'h08;
  localparam logic [7:0] ADDR_PROP_CH1 = 8'h0C;
  localparam logic [7:0] ADDR_PROP_CH2 = 8'h10;
  localparam logic [7:0] ADDR_BRK_DLY  = 8'h14;
  localparam logic [7:0] ADDR_MODE     = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  // Reset values and limits
  localparam logic [15:0]        SRC_SEL_RST   = 16'h0000;
  localparam logic signed [15:0] OFFSET_RST    = 16'sh0000;
  localparam logic [6:0]         PROP_RST      = 7'h64;
  localparam logic [15:0]        BRK_DLY_RST   = 16'h0000;
  localparam logic [7:0]         MODE_RST      = 8'h00;
  localparam logic [7:0]         MODE_BRAKE_EN = 8'h01;
  localparam logic [3:0]         SRC_MAX_CODE  = 4'h9;
  localparam int                 SEL_STRIDE    = 8;
  localparam logic signed [15:0] OFF_MIN       = -16'sd999;
  localparam logic signed [15:0] OFF_MAX       = 16'sd999;
  localparam logic [15:0]        PROP_MAX      = 16'h0064;
  // Datapath widths and scale
  localparam int                 NUM_CH  = 2;
  localparam int                 VAL_W   = 32;
  localparam int                 NUM_W   = 52;
  localparam int                 DEN_W   = 40;
  localparam logic [19:0]        SCALE_NUM   = 20'hF4240;  // 10000 mV times 100 percent
  localparam logic [16:0]        MAG_SAT     = 17'h04E20;  // 20000 mV, beyond any offset
  localparam logic signed [17:0] OUT_MAX_MV  = 18'sh02710; // 10000 mV
  // Fixed full-scale figures
  localparam logic [31:0] FS_LOAD_PCT   = 32'h0000012C; // 300 percent
  localparam logic [31:0] FS_PULSE_PPS  = 32'h0007A120; // 500 kpps
  localparam logic [31:0] FS_BUS_V      = 32'h00000190; // 400 V
  localparam logic [31:0] FS_ERR_WIDE   = 32'h00400000; // 4194304 pulses
  localparam logic [31:0] FS_ERR_MID    = 32'h000003E8; // 1000 pulses
  localparam logic [31:0] FS_ERR_FINE   = 32'h00000064; // 100 pulses
  // Brake delay unit
  localparam int CLK_PERIOD_NS  = 5;
  localparam int BRAKE_UNIT_NS  = 1000000;
  localparam int BRAKE_UNIT_CYC = BRAKE_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SRC_MOTOR_SPEED = 4'h0, SRC_TORQUE = 4'h1, SRC_SPEED_CMD = 4'h2, SRC_LOAD = 4'h3,
    SRC_PULSE_FREQ = 4'h4, SRC_CURRENT_CMD = 4'h5, SRC_BUS_VOLT = 4'h6,
    SRC_ERR_WIDE = 4'h7, SRC_ERR_MID = 4'h8, SRC_ERR_FINE = 4'h9
  } amb_src_t;
  typedef enum logic [1:0] {BRK_LOCKED = 2'b00, BRK_WAIT = 2'b01, BRK_RELEASED = 2'b10} amb_brk_t;
  typedef enum logic {CH_IDLE = 1'b0, CH_RUN = 1'b1} amb_ch_t;
  typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} amb_div_t;
endpackage

// file: logic/amb_top.sv
// Analog monitor channels and brake interlock with APB register access
`timescale 1ns/1ps
module amb_top #(
  parameter int TICK_CYCLES = amb_pkg::BRAKE_UNIT_CYC
) (
  input  wire logic                               clk,
  input  wire logic                               arst_n,
  input  wire logic [7:0]                         paddr,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   motorSpeed,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   genTorque,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   speedCmd,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   loadRatio,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   pulseFreq,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   currentCmd,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   busVolt,
  input  wire logic signed [amb_pkg::VAL_W-1:0]   pulseErr,
  input  wire logic [amb_pkg::VAL_W-2:0]          ratedSpeed,
  input  wire logic [amb_pkg::VAL_W-1:0]          maxTorque,
  input  wire logic [amb_pkg::VAL_W-1:0]          maxCurrent,
  input  wire logic                               servoOnIn,
  output logic signed [15:0]                      monitorOutCh1,
  output logic signed [15:0]                      monitorOutCh2,
  output logic                                    brakeReleaseOut
);
  import amb_pkg::*;

  logic [1:0]         rstPipe_r;
  logic               rstN;
  logic [15:0]        srcSel_r, srcSel_nxt, brakeDly_r, brakeDly_nxt;
  logic signed [15:0] offMv_r [NUM_CH];
  logic signed [15:0] offMv_nxt [NUM_CH];
  logic [6:0]         prop_r [NUM_CH];
  logic [6:0]         prop_nxt [NUM_CH];
  logic [7:0]         mode_r, mode_nxt;
  logic [31:0]        prdata_r, prdata_nxt;
  logic               pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic               accessPh, wrFire, mapped, valueOk;
  logic [15:0]        wd16;
  amb_brk_t           brk_r, brk_nxt;
  logic [31:0]        tickCnt_r, tickCnt_nxt;
  logic [15:0]        msCnt_r, msCnt_nxt;
  logic               brakeRel_r, brakeRel_nxt, modeEn;
  logic signed [15:0] chOut [NUM_CH];

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstN = rstPipe_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data and error come from flops
  assign accessPh = psel & penable;
  assign wrFire   = accessPh & pready_r & pwrite & ~pslverr_r;
  assign wd16     = pwdata[15:0];

  always_comb begin
    mapped  = 1'b1;
    valueOk = 1'b1;
    unique case (paddr)
      ADDR_SRC_SEL: valueOk = (wd16[15:12] == 4'h0) && (wd16[7:4] == 4'h0) &&
                              (wd16[11:8] <= SRC_MAX_CODE) && (wd16[3:0] <= SRC_MAX_CODE);
      ADDR_OFF_CH1, ADDR_OFF_CH2: valueOk = ($signed(wd16) >= OFF_MIN) &&
                                            ($signed(wd16) <= OFF_MAX);
      ADDR_PROP_CH1, ADDR_PROP_CH2: valueOk = (wd16 <= PROP_MAX);
      ADDR_BRK_DLY, ADDR_MODE, ADDR_STATUS: valueOk = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Answer computed in the first access cycle, presented in the second
  always_comb begin
    pready_nxt  = accessPh & ~pready_r;
    pslverr_nxt = accessPh & ~pready_r & (~mapped | (pwrite & ~valueOk) |
                  (pwrite & (paddr == ADDR_STATUS)));
    prdata_nxt  = 32'h0000_0000;
    if (accessPh && !pready_r && !pwrite) begin
      unique case (paddr)
        ADDR_SRC_SEL:  prdata_nxt = {16'h0000, srcSel_r};
        ADDR_OFF_CH1:  prdata_nxt = {16'h0000, offMv_r[0]};
        ADDR_OFF_CH2:  prdata_nxt = {16'h0000, offMv_r[1]};
        ADDR_PROP_CH1: prdata_nxt = {25'h0000000, prop_r[0]};
        ADDR_PROP_CH2: prdata_nxt = {25'h0000000, prop_r[1]};
        ADDR_BRK_DLY:  prdata_nxt = {16'h0000, brakeDly_r};
        ADDR_MODE:     prdata_nxt = {24'h000000, mode_r};
        ADDR_STATUS:   prdata_nxt = {28'h0000000, brakeRel_r, servoOnIn, brk_r};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register writes land on the edge that completes the access
  always_comb begin
    srcSel_nxt   = srcSel_r;
    offMv_nxt    = offMv_r;
    prop_nxt     = prop_r;
    brakeDly_nxt = brakeDly_r;
    mode_nxt     = mode_r;
    if (wrFire) begin
      unique case (paddr)
        ADDR_SRC_SEL:  srcSel_nxt   = wd16;
        ADDR_OFF_CH1:  offMv_nxt[0] = $signed(wd16);
        ADDR_OFF_CH2:  offMv_nxt[1] = $signed(wd16);
        ADDR_PROP_CH1: prop_nxt[0]  = wd16[6:0];
        ADDR_PROP_CH2: prop_nxt[1]  = wd16[6:0];
        ADDR_BRK_DLY:  brakeDly_nxt = wd16;
        ADDR_MODE:     mode_nxt     = pwdata[7:0];
        default:       mode_nxt     = mode_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      srcSel_r   <= SRC_SEL_RST;
      offMv_r    <= '{OFFSET_RST, OFFSET_RST};
      prop_r     <= '{PROP_RST, PROP_RST};
      brakeDly_r <= BRK_DLY_RST;
      mode_r     <= MODE_RST;
    end else begin
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      prdata_r   <= prdata_nxt;
      srcSel_r   <= srcSel_nxt;
      offMv_r    <= offMv_nxt;
      prop_r     <= prop_nxt;
      brakeDly_r <= brakeDly_nxt;
      mode_r     <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brake interlock; dropping servo on or the mode locks at once
  // mode gate
  assign modeEn = (mode_r == MODE_BRAKE_EN);

  always_comb begin
    brk_nxt     = brk_r;
    tickCnt_nxt = 32'h0000_0000;
    msCnt_nxt   = 16'h0000;
    unique case (brk_r)
      BRK_LOCKED: begin
        if (modeEn && servoOnIn) begin
          brk_nxt = (brakeDly_r == 16'h0000) ? BRK_RELEASED : BRK_WAIT;
        end
      end
      BRK_WAIT: begin
        if (!(modeEn && servoOnIn)) begin
          brk_nxt = BRK_LOCKED;
        end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
          msCnt_nxt = msCnt_r + 16'h0001;
          if (msCnt_nxt >= brakeDly_r) begin
            brk_nxt = BRK_RELEASED;
          end
        end else begin
          tickCnt_nxt = tickCnt_r + 32'h0000_0001;
          msCnt_nxt   = msCnt_r;
        end
      end
      BRK_RELEASED: begin
        if (!(modeEn && servoOnIn)) begin
          brk_nxt = BRK_LOCKED;
        end
      end
      default: brk_nxt = BRK_LOCKED;
    endcase
    brakeRel_nxt = (brk_nxt == BRK_RELEASED);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      brk_r      <= BRK_LOCKED;
      tickCnt_r  <= 32'h0000_0000;
      msCnt_r    <= 16'h0000;
      brakeRel_r <= 1'b0;
    end else begin
      brk_r      <= brk_nxt;
      tickCnt_r  <= tickCnt_nxt;
      msCnt_r    <= msCnt_nxt;
      brakeRel_r <= brakeRel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor channels: refreshed once per divider pass
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [3:0]              code;
    logic signed [VAL_W-1:0] val;
    logic [VAL_W-1:0]        fs, absVal;
    logic [NUM_W-1:0]        numer, quot;
    logic [DEN_W-1:0]        denom;
    logic                    done;
    amb_ch_t                 st_r, st_nxt;
    logic                    neg_r, neg_nxt, zero_r, zero_nxt;
    logic signed [15:0]      out_r, out_nxt;
    logic [16:0]             mag;
    logic signed [17:0]      sum;

    assign code = srcSel_r[ch*SEL_STRIDE +: 4];

    // Source and full-scale selection
    always_comb begin
      unique case (code)
        SRC_MOTOR_SPEED: begin val = motorSpeed; fs = {ratedSpeed, 1'b0}; end
        SRC_SPEED_CMD:   begin val = speedCmd;   fs = {ratedSpeed, 1'b0}; end
        SRC_TORQUE:      begin val = genTorque;  fs = maxTorque;  end
        SRC_CURRENT_CMD: begin val = currentCmd; fs = maxCurrent; end
        SRC_LOAD:        begin val = loadRatio;  fs = FS_LOAD_PCT;  end
        SRC_PULSE_FREQ:  begin val = pulseFreq;  fs = FS_PULSE_PPS; end
        SRC_BUS_VOLT:    begin val = busVolt;    fs = FS_BUS_V;     end
        SRC_ERR_WIDE:    begin val = pulseErr;   fs = FS_ERR_WIDE;  end
        SRC_ERR_MID:     begin val = pulseErr;   fs = FS_ERR_MID;   end
        SRC_ERR_FINE:    begin val = pulseErr;   fs = FS_ERR_FINE;  end
        default:         begin val = '0;         fs = FS_ERR_FINE;  end
      endcase
    end

    assign absVal = val[VAL_W-1] ? VAL_W'(-val) : VAL_W'(val);
    assign numer  = NUM_W'(absVal) * NUM_W'(SCALE_NUM);
    assign denom  = DEN_W'(fs) * DEN_W'(prop_r[ch]);

    amb_divider u_div (
      .clk   (clk),
      .rstN  (rstN),
      .start (st_r == CH_IDLE),
      .numer (numer),
      .denom (denom),
      .done  (done),
      .quot  (quot)
    );

    // Zero value short-cuts 0/0, zero proportion saturates by sign
    always_comb begin
      st_nxt   = st_r;
      neg_nxt  = neg_r;
      zero_nxt = zero_r;
      out_nxt  = out_r;
      mag      = (zero_r || quot == '0) ? 17'h00000 :
                 (quot > NUM_W'(MAG_SAT)) ? MAG_SAT : quot[16:0];
      sum      = (neg_r ? -$signed({1'b0, mag}) : $signed({1'b0, mag})) +
                 18'(offMv_r[ch]);
      unique case (st_r)
        CH_IDLE: begin
          neg_nxt  = val[VAL_W-1];
          zero_nxt = (val == '0);
          st_nxt   = CH_RUN;
        end
        CH_RUN: begin
          if (done) begin
            st_nxt = CH_IDLE;
            if (sum > OUT_MAX_MV) begin
              out_nxt = 16'(OUT_MAX_MV);
            end else if (sum < -OUT_MAX_MV) begin
              out_nxt = 16'(-OUT_MAX_MV);
            end else begin
              out_nxt = 16'(sum);
            end
          end
        end
      endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        st_r   <= CH_IDLE;
        neg_r  <= 1'b0;
        zero_r <= 1'b1;
        out_r  <= 16'sh0000;
      end else begin
        st_r   <= st_nxt;
        neg_r  <= neg_nxt;
        zero_r <= zero_nxt;
        out_r  <= out_nxt;
      end
    end
    assign chOut[ch] = out_r;

    a_sign_out: assert property (@(posedge clk) disable iff (!rstN)
      (st_r == CH_RUN && done && offMv_r[ch] == 16'sh0000) |=>
        (neg_r ? out_r <= 16'sh0000 : out_r >= 16'sh0000))
      else $error("monitor sign wrong");
    a_speed_fs: assert property (@(posedge clk) disable iff (!rstN)
      (code == SRC_MOTOR_SPEED) |-> denom == DEN_W'(ratedSpeed) * DEN_W'(2) * DEN_W'(prop_r[ch]))
      else $error("speed scale wrong");
    a_err_fs: assert property (@(posedge clk) disable iff (!rstN)
      (code == SRC_ERR_MID) |-> fs == 32'd1000 && val == pulseErr)
      else $error("pulse error scale wrong");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign monitorOutCh1   = chOut[0];
  assign monitorOutCh2   = chOut[1];
  assign brakeReleaseOut = brakeRel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; onCnt counts how long release has been allowed
  logic [47:0] onCnt_r;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      onCnt_r <= 48'h0;
    end else begin
      onCnt_r <= (modeEn && servoOnIn) ? onCnt_r + 48'h1 : 48'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  a_sel_range: assert property ((srcSel_r[3:0] <= 4'h9) && (srcSel_r[11:8] <= 4'h9)
    && srcSel_r[15:12] == 4'h0 && srcSel_r[7:4] == 4'h0) else $error("select out of range");
  a_off_range: assert property (offMv_r[0] >= -16'sd999 && offMv_r[0] <= 16'sd999
    && offMv_r[1] >= -16'sd999 && offMv_r[1] <= 16'sd999) else $error("offset out of range");
  a_prop_range: assert property (prop_r[0] <= 7'd100 && prop_r[1] <= 7'd100)
    else $error("proportion out of range");
  a_out_clamp: assert property (monitorOutCh1 >= -16'sd10000 && monitorOutCh1 <= 16'sd10000
    && monitorOutCh2 >= -16'sd10000 && monitorOutCh2 <= 16'sd10000) else $error("output not clamped");
  a_lock_off: assert property (!servoOnIn |=> !brakeReleaseOut)
    else $error("brake released without servo on");
  a_mode_gate: assert property ($rose(brakeReleaseOut) |-> $past(mode_r) == 8'h01)
    else $error("brake released with mode disabled");
  a_rel_delay: assert property ($rose(brakeReleaseOut) |->
    onCnt_r > 48'(brakeDly_r) * 48'(TICK_CYCLES)) else $error("brake released too early");
  a_bad_write: assert property ((accessPh && !pready_r && pwrite && paddr == ADDR_PROP_CH1
    && wd16 > 16'd100) |=> pslverr ##1 prop_r[0] == $past(prop_r[0], 2)) else $error("bad write taken");

  c_release:  cover property ($rose(brakeReleaseOut));
  c_neg_out:  cover property (monitorOutCh1 < 16'sh0000);
  c_sat_out:  cover property (monitorOutCh2 == 16'sd10000);
endmodule

// file: test/amb_far_side.sv
// Motor shaft and holding brake seen from the drive's pins
`timescale 1ns/1ps
module amb_far_side (
  input  wire logic               brakeReleaseOut,
  input  wire logic signed [31:0] spdSet,
  output logic signed [31:0]      motorSpeed
);
  ////////////////////////////////////////////////////////////
  // shaft locked while low
  // bench drops servo only when stopped
  // A locked shaft cannot turn, so the speed sensor reads zero
  assign motorSpeed = brakeReleaseOut ? spdSet : 32'sh0;
endmodule

// file: test/testbench.sv
// Self-checking bench for the analog monitor and brake block
`timescale 1ns/1ps
module testbench;
  import amb_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, servoOnIn = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, brakeReleaseOut, errv;
  logic signed [31:0] spdSet = 32'sd3000, motorSpeed, pulseErr = -32'sd50;
  logic signed [31:0] genTorque = 32'sd500, speedCmd = 32'sd3000, loadRatio = 32'sd150;
  logic signed [31:0] pulseFreq = 32'sd250000, currentCmd = 32'sd500, busVolt = 32'sd200;
  logic signed [15:0] monitorOutCh1, monitorOutCh2;
  int failures = 0, samples_checked = 0;
  int exp_tab [10] = '{5000, 5000, 5000, 5000, 5000, 5000, 5000, 0, -500, -5000};
  always #2.5 clk = ~clk;
  amb_far_side amb_far_side_inst (.brakeReleaseOut(brakeReleaseOut), .spdSet(spdSet),
    .motorSpeed(motorSpeed));
  amb_top #(.TICK_CYCLES(4)) amb_top_inst (.clk(clk), .arst_n(arst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motorSpeed(motorSpeed), .genTorque(genTorque),
    .speedCmd(speedCmd), .loadRatio(loadRatio), .pulseFreq(pulseFreq),
    .currentCmd(currentCmd), .busVolt(busVolt), .pulseErr(pulseErr),
    .ratedSpeed(31'd3000), .maxTorque(32'd1000), .maxCurrent(32'd1000),
    .servoOnIn(servoOnIn), .monitorOutCh1(monitorOutCh1), .monitorOutCh2(monitorOutCh2),
    .brakeReleaseOut(brakeReleaseOut));
  ////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 40);
    rdv = prdata; errv = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  // Reset values, unmapped place, refused range errors
  task t_regs;
    apb(0, ADDR_PROP_CH2, 0); chk("prop2", rdv, 32'h64);
    apb(0, ADDR_OFF_CH1, 0); chk("off1", rdv, 32'h0);
    apb(0, 8'h20, 0); chk("unmapped", {31'h0, errv}, 32'h1);
    apb(1, ADDR_SRC_SEL, 32'h0A00); chk("sel err", {31'h0, errv}, 32'h1);
    apb(1, ADDR_OFF_CH2, 32'h03E8); chk("off err", {31'h0, errv}, 32'h1);
    apb(1, ADDR_PROP_CH1, 32'h65); chk("prop err", {31'h0, errv}, 32'h1);
    apb(0, ADDR_PROP_CH1, 0); chk("prop1 kept", rdv, 32'h64);
  endtask
  // Brake waits for mode and for the programmed delay
  task t_brake;
    servoOnIn <= 1; wait_cyc(10);
    chk("brake mode off", {31'h0, brakeReleaseOut}, 32'h0);
    apb(1, ADDR_BRK_DLY, 32'h1); servoOnIn <= 0; apb(1, ADDR_MODE, 32'h01);
    servoOnIn <= 1; wait_cyc(3);
    chk("brake early", {31'h0, brakeReleaseOut}, 32'h0);
    wait_cyc(5); chk("brake out", {31'h0, brakeReleaseOut}, 32'h1);
    apb(0, ADDR_STATUS, 0); chk("status", rdv, 32'hE);
  endtask
  // Every source code on channel 1, channel 2 on motor speed
  task t_codes;
    for (int c = 0; c < 10; c++) begin
      apb(1, ADDR_SRC_SEL, 32'(c)); wait_cyc(120);
      chk("code", monitorOutCh1, 32'(exp_tab[c]));
      chk("ch2", monitorOutCh2, 32'sd5000);
    end
  endtask
  // Offset, proportion, clamp, then reverse speed and brake drop
  task t_scale;
    apb(1, ADDR_SRC_SEL, 32'h0); apb(1, ADDR_PROP_CH1, 32'd50);
    apb(1, ADDR_OFF_CH1, 32'hFE0C); wait_cyc(120);
    chk("prop50", monitorOutCh1, 32'sd9500);
    apb(1, ADDR_OFF_CH1, 32'd500); wait_cyc(120);
    chk("clamp", monitorOutCh1, 32'sd10000);
    spdSet <= -32'sd3000; wait_cyc(120);
    chk("reverse1", monitorOutCh1, -32'sd9500);
    chk("reverse", monitorOutCh2, -32'sd5000);
    spdSet <= 0; wait_cyc(120); servoOnIn <= 0; wait_cyc(2);
    chk("brake drop", {31'h0, brakeReleaseOut}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    wait_cyc(3); arst_n <= 1; wait_cyc(3);
    t_regs; t_brake; t_codes; t_scale;
    wrap_up;
  end
  // Watchdog well past the planned run length
  initial begin
    #200000;
    failures++;
    wrap_up;
  end
endmodule
